// File: hdl/usb_ep_pkg.sv
// Constants, codes and carrier types of the endpoint FIFO glue.
// Assumes one 100 MHz clock shared with the protocol core's application side.
`default_nettype none
package usb_ep_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_EP = 8;
    localparam int EP_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 4;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] MAX_PKT = 10'h3FF;
    localparam int LEN_VALID_BIT = 10;
    localparam int LEN_OK_BIT = 11;
    // ****************************************
    // Register map (byte addresses, paddr[7:0])
    // ****************************************
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FRAME = 8'h08;
    localparam logic [7:0] ADDR_SETUP_LO = 8'h0C;
    localparam logic [7:0] ADDR_SETUP_HI = 8'h10;
    localparam logic [7:0] ADDR_EP_TYPE = 8'h14;
    localparam logic [2:0] REGION_CTRL = 3'h0;
    localparam logic [2:0] REGION_TX = 3'h1;
    localparam logic [2:0] REGION_RX = 3'h2;
    localparam logic [2:0] REGION_LEN = 3'h3;
    localparam int CMD_STALL_LSB = 0;
    localparam int CMD_RESUME_BIT = 8;
    localparam int CMD_START_LSB = 16;
    localparam int CMD_ADDR_LSB = 24;
    localparam int STS_ACK_LSB = 0;
    localparam int STS_TXDONE_LSB = 8;
    localparam int STS_RXDONE_LSB = 16;
    localparam int FRAME_SOF_BIT = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ****************************************
    // Packet identifiers and codes
    // ****************************************
    localparam logic [7:0] PID_OUT = 8'hE1;
    localparam logic [7:0] PID_IN = 8'h69;
    localparam logic [7:0] PID_SOF = 8'hA5;
    localparam logic [7:0] PID_SETUP = 8'h2D;
    typedef enum logic [1:0] {
        HS_SEND = 2'h0,
        HS_NACK = 2'h1,
        HS_STALL = 2'h3
    } hs_e;
    typedef enum logic [1:0] {
        EP_CTRL = 2'h0,
        EP_ISO = 2'h1,
        EP_BULK = 2'h2,
        EP_INTR = 2'h3
    } ep_type_e;
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_OUT = 2'h1,
        PH_IN = 2'h3
    } phase_e;
    // ****************************************
    // Carriers to and from the protocol core
    // ****************************************
    typedef struct packed {
        logic tok_valid;
        logic [7:0] pid;
        logic [10:0] field;
        logic rx_strobe;
        logic [7:0] rx_byte;
        logic rx_end;
        logic rx_ok;
        logic tx_strobe;
        logic tx_end;
        logic host_ack;
    } core_in_s;
    typedef struct packed {
        logic hs_valid;
        hs_e hs_code;
        logic [7:0] tx_byte;
        logic resume;
    } core_out_s;
endpackage
`default_nettype wire

// File: hdl/ep_fifo_mem.sv
// Small dual-port storage for the endpoint FIFOs, registered read data.
// Assumes the caller keeps its own pointers.
`default_nettype none
module ep_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// File: hdl/endpoint_glue_unit.sv
// Endpoint FIFO and control glue between the protocol core and the APB.
// Assumes core strobes are one-cycle pulses on mclk, at least two cycles apart.
//
// Behaviour
// - Eight endpoints; zero is control, seven take iso, bulk or interrupt type.
// - Packets up to 1023 bytes are accepted on every endpoint.
// - Handshakes come from hardware; software may stall any endpoint.
// - Command register stalls endpoints and requests a resume.
// - SETUP payload goes only to setup registers; data stages use FIFOs.
// - Every endpoint has an 8-byte transmit and an 8-byte receive FIFO.
// - CPU fills transmit and drains receive FIFOs through per-endpoint ports.
// - Each FIFO has a packet-complete status flag and output.
// - Transmit word request raised while the start bit is set and the transmit FIFO has room.
// - Receive word request raised while the receive FIFO holds data.
// - Active endpoint FIFO is multiplexed onto each core data bus.
// - Ten-bit counter counts received bytes; length register gets count and status.
// - Each start-of-frame raises a frame event and captures the frame number.
// - IN to non-iso endpoint with empty transmit FIFO gets NACK.
// - OUT to endpoint without free receive FIFO gets NACK.
// - Unread receive byte count makes the next OUT packet NACK.
// - After an IN packet a status bit shows host acknowledge.
// - SOF, SETUP, IN and OUT decoded from the 8-bit packet identifier.
// - SOF carries an 11-bit frame number.
// - Tokens carry 7-bit address and 4-bit endpoint number.
// - Protocol core acts as master on the application side of this block.
// - Transfer engine fills transmit FIFOs on word requests.
// - Transfer engine drains receive FIFOs on word requests.
// - Reading the receive byte count clears it and frees the FIFO once drained.
// - Transmit word requests only after the transfer start bit is set.
`default_nettype none
module endpoint_glue_unit (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire usb_ep_pkg::core_in_s core_in,
    output usb_ep_pkg::core_out_s core_out,
    output logic [usb_ep_pkg::NUM_EP-1:0] tx_word_request,
    output logic [usb_ep_pkg::NUM_EP-1:0] rx_word_request,
    output logic [usb_ep_pkg::NUM_EP-1:0] tx_packet_done,
    output logic [usb_ep_pkg::NUM_EP-1:0] rx_packet_done,
    output logic sof_event
);
    import usb_ep_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [NUM_EP-1:0] stall, start, in_acked, rx_wait, resume;
    logic [6:0] dev_addr;
    logic [2*NUM_EP-1:0] ep_types;
    logic [10:0] frame_num;
    logic sof_flag, setup_pend, act_ok, act_setup, hs_valid;
    logic [63:0] setup_data;
    logic [2:0] setup_idx;
    logic [PTR_W-1:0] tx_wp [NUM_EP];
    logic [PTR_W-1:0] tx_rp [NUM_EP];
    logic [PTR_W-1:0] rx_wp [NUM_EP];
    logic [PTR_W-1:0] rx_rp [NUM_EP];
    logic [11:0] rx_len [NUM_EP];
    logic [CNT_W-1:0] rx_cnt;
    logic rx_ovf;
    logic [EP_W-1:0] act_ep;
    phase_e phase;
    hs_e hs_code, next_hs;
    logic [NUM_EP-1:0] tx_empty, tx_full, rx_empty, rx_full, rx_busy;
    logic [7:0] tx_rdata, rx_rdata;
    logic [31:0] next_prdata;
    logic next_err;

    // ****************************************
    // APB decode
    // ****************************************
    logic acc, wr_en, rd_en;
    logic [2:0] region;
    logic [EP_W-1:0] sel_ep;
    assign acc = psel & penable & pready;
    assign wr_en = acc & pwrite;
    assign rd_en = acc & ~pwrite;
    assign region = paddr[7:5];
    assign sel_ep = paddr[4:2];

    // ****************************************
    // Token decode
    // ****************************************
    logic tok, for_me, is_in, is_out, is_setup, is_sof, tok_hs, rx_take, tx_take;
    logic [EP_W-1:0] tok_ep;
    assign is_in = core_in.pid == PID_IN;
    assign is_out = core_in.pid == PID_OUT;
    assign is_setup = core_in.pid == PID_SETUP;
    assign is_sof = core_in.pid == PID_SOF;
    assign tok_ep = core_in.field[9:7];
    assign for_me = core_in.field[6:0] == dev_addr && !core_in.field[10];
    assign tok = core_in.tok_valid;
    assign tok_hs = tok & for_me & (is_in | is_out | is_setup);
    // core strobes qualified by the active transaction
    assign rx_take = core_in.rx_strobe & (phase == PH_OUT) & act_ok;
    assign tx_take = core_in.tx_strobe & (phase == PH_IN) & ~tx_empty[act_ep];

    always_comb begin
        next_hs = HS_SEND;
        if (is_setup) begin
            if (setup_pend) begin
                next_hs = HS_NACK;
            end
        end else if (stall[tok_ep]) begin
            next_hs = HS_STALL;
        end else if (tok_ep == '0 && setup_pend) begin
            next_hs = HS_NACK;
        end else if (is_in) begin
            if (tx_empty[tok_ep] && ep_type_e'(ep_types[{tok_ep, 1'b0} +: 2]) != EP_ISO) begin
                next_hs = HS_NACK;
            end
        end else if (rx_busy[tok_ep]) begin
            next_hs = HS_NACK;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hs_valid <= 1'b0;
            hs_code <= HS_SEND;
        end else begin
            hs_valid <= tok_hs;
            hs_code <= tok_hs ? next_hs : hs_code;
        end
    end

    // one transaction owns the core buses
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_IDLE;
            act_ep <= '0;
            act_ok <= 1'b0;
            act_setup <= 1'b0;
        end else if (tok_hs) begin
            act_ep <= tok_ep;
            act_ok <= next_hs == HS_SEND;
            act_setup <= is_setup;
            phase <= is_in ? PH_IN : PH_OUT;
        end else begin
            unique case (phase)
                PH_IDLE: phase <= PH_IDLE;
                PH_OUT: phase <= core_in.rx_end ? PH_IDLE : PH_OUT;
                PH_IN: phase <= core_in.tx_end ? PH_IDLE : PH_IN;
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // ****************************************
    // Receive counter, frame and setup capture
    // ****************************************
    // byte counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_cnt <= '0;
            rx_ovf <= 1'b0;
        end else if (tok_hs) begin
            rx_cnt <= '0;
            rx_ovf <= 1'b0;
        end else if (rx_take && !act_setup) begin
            rx_cnt <= (rx_cnt == MAX_PKT) ? rx_cnt : rx_cnt + 10'h001;
            rx_ovf <= rx_ovf | rx_full[act_ep];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            frame_num <= '0;
            sof_flag <= 1'b0;
            sof_event <= 1'b0;
        end else begin
            sof_event <= tok & is_sof;
            if (tok && is_sof) begin
                frame_num <= core_in.field;
            end
            sof_flag <= (tok & is_sof) | (sof_flag &
                ~(wr_en & paddr == ADDR_FRAME & pwdata[FRAME_SOF_BIT]));
        end
    end

    // setup payload kept apart from the FIFOs
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            setup_data <= '0;
            setup_idx <= '0;
            setup_pend <= 1'b0;
        end else begin
            if (tok_hs) begin
                setup_idx <= '0;
            end else if (rx_take && act_setup) begin
                setup_data[{setup_idx, 3'b000} +: 8] <= core_in.rx_byte;
                setup_idx <= setup_idx + 3'h1;
            end
            if (phase == PH_OUT && core_in.rx_end && act_ok && act_setup && core_in.rx_ok) begin
                setup_pend <= 1'b1;
            end else if (rd_en && paddr == ADDR_SETUP_HI) begin
                setup_pend <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // stall, resume and address
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stall <= RST_WORD[NUM_EP-1:0];
            dev_addr <= RST_WORD[6:0];
            ep_types <= RST_WORD[2*NUM_EP-1:0];
            resume <= '0;
        end else begin
            resume <= '0;
            if (wr_en && paddr == ADDR_CMD) begin
                stall <= pwdata[CMD_STALL_LSB +: NUM_EP];
                dev_addr <= pwdata[CMD_ADDR_LSB +: 7];
                resume[0] <= pwdata[CMD_RESUME_BIT];
            end
            if (wr_en && paddr == ADDR_EP_TYPE) begin
                ep_types <= {pwdata[2*NUM_EP-1:2], 2'(EP_CTRL)};
            end
        end
    end

    // ****************************************
    // Per-endpoint FIFO pointers and flags
    // ****************************************
    logic [NUM_EP-1:0] txdone, rxdone;
    logic tx_push, rx_push;
    assign tx_push = wr_en & region == REGION_TX & ~tx_full[sel_ep];
    assign rx_push = rx_take & ~act_setup & ~rx_full[act_ep];

    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        logic end_in, end_out, sts_clr, start_set;
        assign tx_empty[e] = tx_wp[e] == tx_rp[e];
        assign tx_full[e] = (tx_wp[e] ^ tx_rp[e]) == 4'h8;
        assign rx_empty[e] = rx_wp[e] == rx_rp[e];
        assign rx_full[e] = (rx_wp[e] ^ rx_rp[e]) == 4'h8;
        assign rx_busy[e] = ~rx_empty[e] | rx_len[e][LEN_VALID_BIT] | rx_wait[e];
        assign end_in = core_in.tx_end & phase == PH_IN & act_ep == e;
        assign end_out = core_in.rx_end & phase == PH_OUT & act_ok & ~act_setup & act_ep == e;
        assign sts_clr = wr_en & paddr == ADDR_STATUS;
        assign start_set = wr_en & paddr == ADDR_CMD & pwdata[CMD_START_LSB + e];

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                tx_wp[e] <= '0;
                tx_rp[e] <= '0;
                rx_wp[e] <= '0;
                rx_rp[e] <= '0;
            end else begin
                if (tx_push && sel_ep == e) begin
                    tx_wp[e] <= tx_wp[e] + 4'h1;
                end
                if (tx_take && act_ep == e) begin
                    tx_rp[e] <= tx_rp[e] + 4'h1;
                end
                if (rx_push && act_ep == e) begin
                    rx_wp[e] <= rx_wp[e] + 4'h1;
                end
                if (rd_en && region == REGION_RX && sel_ep == e && !rx_empty[e]) begin
                    rx_rp[e] <= rx_rp[e] + 4'h1;
                end
            end
        end

        // start bit, cleared by packet end
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                start[e] <= 1'b0;
                in_acked[e] <= 1'b0;
                txdone[e] <= 1'b0;
                rxdone[e] <= 1'b0;
                rx_wait[e] <= 1'b0;
                rx_len[e] <= '0;
            end else begin
                start[e] <= start_set | (start[e] & ~end_in);
                if (end_in) begin
                    in_acked[e] <= core_in.host_ack;
                end
                txdone[e] <= end_in | (txdone[e] & ~(sts_clr & pwdata[STS_TXDONE_LSB + e]));
                rxdone[e] <= (rx_wait[e] & rx_empty[e])
                    | (rxdone[e] & ~(sts_clr & pwdata[STS_RXDONE_LSB + e]));
                rx_wait[e] <= end_out | (rx_wait[e] & ~rx_empty[e]);
                // length and status captured at packet end
                if (end_out) begin
                    rx_len[e] <= {core_in.rx_ok & ~rx_ovf, 1'b1, rx_cnt};
                end else if (rd_en && region == REGION_LEN && sel_ep == e) begin
                    rx_len[e] <= '0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_word_request <= '0;
            rx_word_request <= '0;
            tx_packet_done <= '0;
            rx_packet_done <= '0;
        end else begin
            tx_word_request <= start & ~tx_full;
            rx_word_request <= ~rx_empty;
            tx_packet_done <= txdone;
            rx_packet_done <= rxdone;
        end
    end

    // ****************************************
    // FIFO storage
    // ****************************************
    // active endpoint selects core-side storage rows, sel_ep the CPU-side rows
    ep_fifo_mem #(.WIDTH(8), .DEPTH(NUM_EP * FIFO_DEPTH), .AW(EP_W + 3)) u_tx_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .we(tx_push),
        .waddr({sel_ep, tx_wp[sel_ep][2:0]}),
        .wdata(pwdata[7:0]),
        .raddr({act_ep, tx_rp[act_ep][2:0]}),
        .rdata(tx_rdata)
    );
    ep_fifo_mem #(.WIDTH(8), .DEPTH(NUM_EP * FIFO_DEPTH), .AW(EP_W + 3)) u_rx_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .we(rx_push),
        .waddr({act_ep, rx_wp[act_ep][2:0]}),
        .wdata(core_in.rx_byte),
        .raddr({sel_ep, rx_rp[sel_ep][2:0]}),
        .rdata(rx_rdata)
    );
    assign core_out = '{hs_valid: hs_valid, hs_code: hs_code, tx_byte: tx_rdata,
        resume: resume[0]};

    // ****************************************
    // APB read mux and answer
    // ****************************************
    always_comb begin
        next_prdata = RST_WORD;
        next_err = 1'b0;
        unique case (region)
            REGION_CTRL: begin
                unique case (paddr)
                    ADDR_CMD: next_prdata = {1'b0, dev_addr, start, 8'h00, stall};
                    ADDR_STATUS: next_prdata = {7'h00, setup_pend, rxdone, txdone, in_acked};
                    ADDR_FRAME: next_prdata = {15'h0000, sof_flag, 5'h00, frame_num};
                    ADDR_SETUP_LO: next_prdata = setup_data[31:0];
                    ADDR_SETUP_HI: next_prdata = setup_data[63:32];
                    ADDR_EP_TYPE: next_prdata = {16'h0000, ep_types};
                    default: next_err = 1'b1;
                endcase
            end
            REGION_TX: next_err = ~pwrite | tx_full[sel_ep];
            REGION_RX: begin
                next_prdata = {24'h000000, rx_rdata};
                next_err = pwrite | rx_empty[sel_ep];
            end
            REGION_LEN: next_prdata = {20'h00000, rx_len[sel_ep]};
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? RST_WORD : next_prdata;
                pslverr <= next_err;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence seq_cmd_write;
        wr_en && paddr == ADDR_CMD;
    endsequence
    sequence seq_in_token;
        tok && for_me && is_in;
    endsequence

    AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not one wait state");
    AST_STALL_IN: assert property (seq_in_token and stall[tok_ep]
        |=> hs_valid && hs_code == HS_STALL)
        else $error("stalled endpoint not answered with stall");
    AST_RESUME_PULSE: assert property (seq_cmd_write ##0 pwdata[CMD_RESUME_BIT]
        |=> core_out.resume ##1 !core_out.resume)
        else $error("resume not a single pulse");
    AST_IN_EMPTY_NACK: assert property (seq_in_token and !stall[tok_ep] && tok_ep != '0
        && tx_empty[tok_ep] && ep_type_e'(ep_types[{tok_ep, 1'b0} +: 2]) != EP_ISO
        |=> hs_code == HS_NACK)
        else $error("IN on empty FIFO not refused");
    AST_OUT_BUSY_NACK: assert property (tok && for_me && is_out && !stall[tok_ep]
        && rx_busy[tok_ep] |=> hs_valid && hs_code == HS_NACK)
        else $error("OUT on busy endpoint not refused");
    AST_LEN_CLEAR: assert property (rd_en && region == REGION_LEN
        && !(phase == PH_OUT && core_in.rx_end) |=> rx_len[$past(sel_ep)] == '0)
        else $error("byte count not cleared by read");
    AST_TXREQ_START: assert property (tx_word_request != '0
        |-> (tx_word_request & ~$past(start)) == '0)
        else $error("transmit request without start bit");
    AST_SOF_CAPTURE: assert property (tok && is_sof
        |=> sof_event && sof_flag && frame_num == $past(core_in.field))
        else $error("frame not captured");
    AST_SETUP_HOLD: assert property (setup_pend && !(rd_en && paddr == ADDR_SETUP_HI)
        |=> setup_pend && $stable(setup_data))
        else $error("pending setup payload changed");
    AST_RXCNT_LIMIT: assert property (rx_cnt == MAX_PKT && rx_take |=> rx_cnt == MAX_PKT)
        else $error("receive counter wrapped");
endmodule
`default_nettype wire

// File: dv/core_model.sv
// Protocol core stand-in driving token, byte and end pulses.
// Assumes callers start right after a rising mclk edge.
`default_nettype none
module core_model (
    input wire logic mclk,
    output usb_ep_pkg::core_in_s core_in
);
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial core_in = '0;
    task automatic send(input core_in_s v);
        core_in_s z;
        z = '0;
        z.rx_byte = ~v.rx_byte;
        core_in <= v;
        @(posedge mclk);
        core_in <= z;
        repeat (2) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Bench: APB master, core model and scenario tasks.
// Assumes the package, glue unit and core model compile first.
`default_nettype none
module tb_top;
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, err, sof_event;
    core_in_s core_in;
    core_out_s core_out;
    logic [7:0] txr, rxr, txd, rxd;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int sofs = 0;
    int rsms = 0;
    int hsvs = 0;
    always #5 mclk = ~mclk;
    endpoint_glue_unit dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_in(core_in), .core_out(core_out), .tx_word_request(txr),
        .rx_word_request(rxr), .tx_packet_done(txd), .rx_packet_done(rxd),
        .sof_event(sof_event));
    core_model cm (.mclk(mclk), .core_in(core_in));
    // ****
    // Tasks
    // ****
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (sof_event === 1'b1) begin
            sofs <= sofs + 1;
        end
        if (core_out.resume === 1'b1) begin
            rsms <= rsms + 1;
        end
        if (core_out.hs_valid === 1'b1) begin
            hsvs <= hsvs + 1;
        end
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic ev(input logic [5:0] k, input logic [7:0] b);
        core_in_s c;
        c = '0;
        {c.tok_valid, c.rx_strobe, c.rx_end, c.rx_ok, c.tx_strobe, c.tx_end} = k;
        c.host_ack = c.tx_end;
        c.rx_byte = b;
        c.pid = b;
        c.field = {b[3:0], 7'h00};
        cm.send(c);
    endtask
    task automatic token(input logic [7:0] p, input logic [10:0] f);
        core_in_s c;
        c = '0;
        c.tok_valid = 1'b1;
        c.pid = p;
        c.field = f;
        cm.send(c);
    endtask
    task automatic hs(input hs_e e);
        chk("hs", 32'(core_out.hs_code), 32'(e));
    endtask
    task automatic out_pkt();
        token(PID_OUT, 11'h080);
        hs(HS_SEND);
        ev(6'h10, 8'h5A);
        ev(6'h10, 8'hC3);
        ev(6'h0C, 8'h00);
        chk("rxreq", 32'(rxr), 32'h2);
        token(PID_OUT, 11'h080);
        hs(HS_NACK);
        apb(1'b0, 8'h44, 32'h0);
        chk("rx0", r, 32'h5A);
        apb(1'b0, 8'h44, 32'h0);
        chk("rx1", r, 32'hC3);
        repeat (3) @(posedge mclk);
        chk("rxdone", 32'(rxd), 32'h2);
        apb(1'b0, 8'h64, 32'h0);
        chk("len", r, 32'hC02);
        apb(1'b0, 8'h64, 32'h0);
        chk("len2", r, 32'h0);
    endtask
    task automatic in_pkt();
        apb(1'b1, ADDR_EP_TYPE, 32'h20);
        token(PID_IN, 11'h100);
        hs(HS_NACK);
        chk("txreq0", 32'(txr), 32'h0);
        apb(1'b1, 8'h28, 32'h96);
        apb(1'b1, ADDR_CMD, 32'h0004_0000);
        repeat (2) @(posedge mclk);
        chk("txreq", 32'(txr), 32'h4);
        token(PID_IN, 11'h100);
        hs(HS_SEND);
        chk("txbyte", 32'(core_out.tx_byte), 32'h96);
        ev(6'h02, 8'h00);
        ev(6'h01, 8'h00);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", r, 32'h0002_0404);
        chk("txdone", 32'(txd), 32'h4);
    endtask
    task automatic setup_pkt();
        token(PID_SETUP, 11'h000);
        hs(HS_SEND);
        for (int i = 1; i <= 8; i++) begin
            ev(6'h10, 8'(i));
        end
        ev(6'h0C, 8'h00);
        chk("setup_fifo", 32'(rxr), 32'h0);
        token(PID_IN, 11'h000);
        hs(HS_NACK);
        token(PID_SETUP, 11'h000);
        hs(HS_NACK);
        ev(6'h10, 8'hEE);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("setup_pend", r, 32'h0102_0404);
        apb(1'b0, ADDR_SETUP_LO, 32'h0);
        chk("setup_lo", r, 32'h0403_0201);
        apb(1'b0, ADDR_SETUP_HI, 32'h0);
        chk("setup_hi", r, 32'h0807_0605);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("setup_free", r, 32'h0002_0404);
    endtask
    task automatic misc();
        apb(1'b1, ADDR_CMD, 32'h108);
        token(PID_IN, 11'h180);
        hs(HS_STALL);
        token(PID_SOF, 11'h280);
        apb(1'b0, ADDR_FRAME, 32'h0);
        chk("frame", r, 32'h0001_0280);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        chk("resume", rsms, 32'h1);
        chk("sofev", sofs, 32'h1);
        chk("hsv", hsvs, 32'h8);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        chk("rst", {txr, rxr, txd, rxd}, 32'h0);
        @(posedge mclk);
        out_pkt();
        in_pkt();
        setup_pkt();
        misc();
        tally_and_finish();
    end
endmodule
`default_nettype wire
